// file: hdl/shcf_framer.sv
/*
 * One synchronous framer channel: SDLC and character sync modes, transmit
 * and receive framing, CRC, abort, receive FIFO with lock, DMA requests.
 * Assumes a single 250 MHz clock; line clocks, data and CTS arrive
 * asynchronously and are sampled through two flops.
 */
// What this block does
// - Auto enable: CTS high halts transmit immediately
// - Special condition locks FIFO in two modes
// - Special event after that character read, or at its push in all-character mode
// - Last CRC char: two CRC1 bits, six CRC2
// - Underrun sends CRC, abort, or flags in SDLC and syncs in character modes
// - CRC or abort load sets message latch
// - Buffer empty after CRC only at the closing flag, or closing sync in character modes
// - New data beats next idle flag
// - Request toggles at flag load, else follows
// - Receive samples on rising pin clock edges or on the phase lock count
// - Phase lock: first transition in search mode, early transitions hold the count
// - Flags stripped, address is first character
// - Parity bit follows data bits
// - No transparency handling, CRC skips parity bits
// - Abort sends eight ones after the current character
// - Seven ones: abort once, then hunt
// - Sync characters sent at exact length
// - Leading syncs and flags stripped silently
// - Bisync sends syncs before first byte
`timescale 1ns/100ps

`include "shcf_defs.svh"

module shcf_framer (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [2:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [15:0] O_RDATA,
	input wire logic I_RECEIVE_CLOCK_PIN,
	input wire logic I_RXD,
	input wire logic I_TXC,
	input wire logic I_CTS_N,
	output logic O_TXD,
	output logic O_WREQ,
	output logic O_RX_DMA_REQ,
	output logic O_TX_EVT,
	output logic O_EXT_EVT,
	output logic O_RX_EVT,
	output logic O_SPEC_EVT
);

	function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
		crc_bit = (c[0] ^ b) ? ((c >> 1) ^ `SHCF_CRC_POLY) : (c >> 1);
	endfunction : crc_bit

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = crc_bit(r, d[i]);
		crc_byte = r;
	endfunction : crc_byte

	function automatic logic [4:0] sync_bits(input logic [1:0] s);
		unique case (s)
			2'h0: sync_bits = 5'h08;
			2'h1: sync_bits = 5'h06;
			2'h2: sync_bits = 5'h0C;
			2'h3: sync_bits = 5'h10;
		endcase
	endfunction : sync_bits

	////////////////////////////////////////////////////////////////////////
	// Registers and bus

	shcf_pkg::shcf_ctrl_t ctrl_q;
	logic [15:0] sync_q;
	logic [15:0] misc_q;
	logic [15:0] rdata_q;
	logic wr_cmd;
	logic rd_data;
	logic eom_rst;
	logic err_rst;
	logic [15:0] status;
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic rclk_s;
	logic rxd_s;
	logic txc_s;
	logic cts_s;
	logic tx_run;
	logic tx_edge;
	logic [4:0] slen;
	logic [15:0] smask;

	assign wr_cmd = I_WR && I_ADDR == `SHCF_COMMAND_REGISTER;
	assign rd_data = I_RD && I_ADDR == `SHCF_DATA_REG;
	assign eom_rst = wr_cmd
		&& I_WDATA[`SHCF_CMD_CRC_HI:`SHCF_CMD_CRC_LO] == `SHCF_CRC_MSG_RST;
	assign err_rst = wr_cmd && I_WDATA[`SHCF_CMD_OP_HI:`SHCF_CMD_OP_LO] == `SHCF_OP_ERR_RST;
	assign slen = sync_bits(ctrl_q.sync_len);
	assign smask = 16'hFFFF >> (5'h10 - slen);

	always_ff @(posedge I_CLK)
		if (I_RST)
		begin
			ctrl_q <= `SHCF_CTRL_RST;
			sync_q <= `SHCF_SYNC_RST;
			misc_q <= `SHCF_MISC_RST;
		end
		else if (I_WR)
		begin
			if (I_ADDR == `SHCF_CTRL_REG)
				ctrl_q <= I_WDATA;
			if (I_ADDR == `SHCF_SYNC_REG)
				sync_q <= I_WDATA;
			if (I_ADDR == `SHCF_MISC_CONTROL_REGISTER)
				misc_q <= I_WDATA;
		end

	// Line inputs pass two flops, third flop for edges
	always_ff @(posedge I_CLK)
		if (I_RST)
		begin
			s1_q <= 4'hF;
			s2_q <= 4'hF;
			s3_q <= 4'hF;
		end
		else
		begin
			s1_q <= {I_CTS_N, I_TXC, I_RXD, I_RECEIVE_CLOCK_PIN};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end

	assign rclk_s = s2_q[0];
	assign rxd_s = s2_q[1];
	assign txc_s = s2_q[2];
	assign cts_s = s2_q[3];
	assign tx_run = ctrl_q.tx_en && !(ctrl_q.auto_en && cts_s);
	assign tx_edge = tx_run && s3_q[2] && !txc_s;

	////////////////////////////////////////////////////////////////////////
	// Transmitter

	logic [31:0] tsh_q;
	logic [5:0] tcnt_q;
	logic tstf_q;
	logic tcrcon_q;
	logic [2:0] tones_q;
	logic [15:0] tcrc_q;
	logic txd_q;
	logic [7:0] tbuf_q;
	logic tbuf_full_q;
	logic in_frame_q;
	logic eom_q;
	logic crc_pend_q;
	logic abort_req_q;
	logic [1:0] sync_left_q;
	logic wreq_q;
	logic tx_empty_q;
	shcf_pkg::shcf_tkind_t ld_kind;
	logic [31:0] ld_val;
	logic [5:0] ld_len;
	logic ld_stf;
	logic sdlc;
	logic [31:0] cur_sh;
	logic [5:0] cur_cnt;
	logic cur_stf;
	logic cur_crc;
	logic load_now;
	logic flag_load;
	logic [15:0] sync_char;

	assign sdlc = ctrl_q.mode == shcf_pkg::SHCF_SDLC;
	assign sync_char = sync_q & smask;

	always_comb
	begin
		ld_kind = shcf_pkg::SHCF_TK_IDLE;
		ld_val = {16'h0000, sync_char};
		ld_len = {1'b0, slen};
		ld_stf = 1'b0;
		if (abort_req_q)
		begin
			ld_kind = shcf_pkg::SHCF_TK_ABORT;
			ld_val = {24'h000000, `SHCF_ONES};
			ld_len = 6'h08;
		end
		else if (sync_left_q != 2'h0)
			ld_kind = shcf_pkg::SHCF_TK_SYNC;
		else if (tbuf_full_q)
		begin
			ld_kind = shcf_pkg::SHCF_TK_DATA;
			ld_val = {23'h000000, ^tbuf_q, tbuf_q};
			ld_len = ctrl_q.parity ? 6'h09 : 6'h08;
			ld_stf = sdlc;
		end
		else if (in_frame_q && !eom_q)
		begin
			ld_stf = sdlc;
			if (ctrl_q.abort_ur && sdlc)
			begin
				ld_kind = shcf_pkg::SHCF_TK_ABORT;
				ld_val = {24'h000000, `SHCF_ONES};
				ld_len = 6'h08;
				ld_stf = 1'b0;
			end
			else
			begin
				ld_kind = shcf_pkg::SHCF_TK_CRC;
				ld_val = {16'h0000, ~tcrc_q};
				ld_len = 6'h10;
			end
		end
		else
		begin
			if (in_frame_q)
				ld_kind = shcf_pkg::SHCF_TK_CLOSE;
			if (sdlc)
			begin
				ld_val = {24'h000000, (ctrl_q.idle_ones && !in_frame_q) ? `SHCF_ONES : `SHCF_FLAG};
				ld_len = 6'h08;
			end
		end
	end

	assign load_now = tx_edge && tcnt_q == 6'h00;
	assign flag_load = load_now && sdlc && ld_val[7:0] == `SHCF_FLAG
		&& (ld_kind == shcf_pkg::SHCF_TK_CLOSE || ld_kind == shcf_pkg::SHCF_TK_IDLE);
	assign cur_sh = load_now ? ld_val : tsh_q;
	assign cur_cnt = load_now ? ld_len : tcnt_q;
	assign cur_stf = load_now ? ld_stf : tstf_q;
	assign cur_crc = load_now ? ld_kind == shcf_pkg::SHCF_TK_DATA : tcrcon_q;

	// Shifter with zero insertion after five ones
	always_ff @(posedge I_CLK)
		if (I_RST)
		begin
			tsh_q <= 32'h00000000;
			tcnt_q <= 6'h00;
			tstf_q <= 1'b0;
			tcrcon_q <= 1'b0;
			tones_q <= 3'h0;
			txd_q <= 1'b1;
		end
		else if (!tx_run)
			txd_q <= 1'b1;
		else if (tx_edge)
		begin
			tstf_q <= cur_stf;
			tcrcon_q <= cur_crc;
			if (tones_q == 3'h5)
			begin
				txd_q <= 1'b0;
				tones_q <= 3'h0;
				tsh_q <= cur_sh;
				tcnt_q <= cur_cnt;
			end
			else
			begin
				txd_q <= cur_sh[0];
				tsh_q <= cur_sh >> 1;
				tcnt_q <= cur_cnt - 6'h01;
				tones_q <= (cur_stf && cur_sh[0]) ? tones_q + 3'h1 : 3'h0;
			end
		end

	// CRC covers every data bit; parity bits and inserted zeros excluded
	always_ff @(posedge I_CLK)
		if (I_RST)
			tcrc_q <= `SHCF_CRC_INIT;
		else if (wr_cmd && I_WDATA[`SHCF_CMD_CRC_HI:`SHCF_CMD_CRC_LO] == `SHCF_CRC_TX_RST)
			tcrc_q <= `SHCF_CRC_INIT;
		else if (load_now && ld_kind == shcf_pkg::SHCF_TK_CRC)
			tcrc_q <= `SHCF_CRC_INIT;
		else if (tx_edge && cur_crc && tones_q != 3'h5
			&& !(ctrl_q.parity && cur_cnt == 6'h01))
			tcrc_q <= crc_bit(tcrc_q, cur_sh[0]);

	// Frame state; a set beats a same-cycle clear
	always_ff @(posedge I_CLK)
		if (I_RST)
		begin
			tbuf_q <= 8'h00;
			tbuf_full_q <= 1'b0;
			in_frame_q <= 1'b0;
			eom_q <= 1'b1;
			crc_pend_q <= 1'b0;
			abort_req_q <= 1'b0;
			sync_left_q <= 2'h0;
		end
		else
		begin
			if (load_now && ld_kind == shcf_pkg::SHCF_TK_DATA)
				tbuf_full_q <= 1'b0;
			if (I_WR && I_ADDR == `SHCF_DATA_REG)
			begin
				tbuf_q <= I_WDATA[7:0];
				tbuf_full_q <= 1'b1;
				if (!sdlc && !in_frame_q && sync_left_q == 2'h0)
					sync_left_q <= (ctrl_q.mode == shcf_pkg::SHCF_BISYNC) ? 2'h2 : 2'h1;
			end
			else if (load_now && ld_kind == shcf_pkg::SHCF_TK_SYNC)
				sync_left_q <= sync_left_q - 2'h1;
			if (load_now && ld_kind == shcf_pkg::SHCF_TK_DATA)
				in_frame_q <= 1'b1;
			else if (load_now && ld_kind == shcf_pkg::SHCF_TK_CLOSE)
				in_frame_q <= 1'b0;
			if (load_now && (ld_kind == shcf_pkg::SHCF_TK_CRC || ld_kind == shcf_pkg::SHCF_TK_ABORT))
				eom_q <= 1'b1;
			else if (eom_rst)
				eom_q <= 1'b0;
			if (load_now && ld_kind == shcf_pkg::SHCF_TK_CRC)
				crc_pend_q <= 1'b1;
			else if (load_now && ld_kind == shcf_pkg::SHCF_TK_CLOSE)
				crc_pend_q <= 1'b0;
			if (wr_cmd && I_WDATA[`SHCF_CMD_OP_HI:`SHCF_CMD_OP_LO] == `SHCF_OP_ABORT)
				abort_req_q <= 1'b1;
			else if (load_now && ld_kind == shcf_pkg::SHCF_TK_ABORT)
				abort_req_q <= 1'b0;
		end

	// Empty status, request line and transmit events
	always_ff @(posedge I_CLK)
		if (I_RST)
		begin
			tx_empty_q <= 1'b1;
			wreq_q <= 1'b0;
			O_TX_EVT <= 1'b0;
		end
		else
		begin
			tx_empty_q <= !tbuf_full_q && !crc_pend_q;
			wreq_q <= ctrl_q.tx_en && ((!tbuf_full_q && !crc_pend_q) ^ flag_load);
			O_TX_EVT <= ctrl_q.tx_ie && !tx_empty_q && !tbuf_full_q && !crc_pend_q;
		end

	assign O_TXD = txd_q;
	assign O_WREQ = wreq_q;

	////////////////////////////////////////////////////////////////////////
	// Receive bit clock: pin edges or phase lock loop

	logic [7:0] dcnt_q;
	logic search_q;
	logic rx_stb;
	logic [7:0] half;

	assign half = {1'b0, misc_q[`SHCF_MISC_DIV_HI:`SHCF_MISC_DIV_LO+1]};

	always_ff @(posedge I_CLK)
		if (I_RST)
		begin
			dcnt_q <= 8'h00;
			search_q <= 1'b0;
		end
		else if (I_WR && I_ADDR == `SHCF_MISC_CONTROL_REGISTER && I_WDATA[`SHCF_MISC_SEARCH])
			search_q <= 1'b1;
		else if (rxd_s != s3_q[1] && search_q)
		begin
			dcnt_q <= 8'h00;
			search_q <= 1'b0;
		end
		else if (rxd_s != s3_q[1] && dcnt_q != 8'h00 && dcnt_q < half)
			dcnt_q <= dcnt_q;
		else if (dcnt_q >= misc_q[`SHCF_MISC_DIV_HI:`SHCF_MISC_DIV_LO] - 8'h01)
			dcnt_q <= 8'h00;
		else
			dcnt_q <= dcnt_q + 8'h01;

	assign rx_stb = ctrl_q.rx_en && (misc_q[`SHCF_MISC_PLL_SEL] ? (dcnt_q == half && !search_q)
		: (rclk_s && !s3_q[0]));

	////////////////////////////////////////////////////////////////////////
	// Receiver framing

	logic [15:0] rhist_q;
	logic [15:0] hist_n;
	logic [2:0] rones_q;
	logic [3:0] rcnt_q;
	logic [8:0] rchr_q;
	logic [8:0] full;
	logic [7:0] rbyte;
	logic rperr;
	logic hunt_q;
	logic lead_q;
	logic [1:0] nchar_q;
	logic pend_v_q;
	shcf_pkg::shcf_rxent_t pend_q;
	logic [7:0] last_q;
	logic [15:0] rcrc_q;
	logic push_q;
	shcf_pkg::shcf_rxent_t push_e_q;
	logic abort_evt_q;
	logic hunt_evt_q;

	assign hist_n = {rxd_s, rhist_q[15:1]};
	assign full = {rxd_s, rchr_q[8:1]};
	assign rbyte = ctrl_q.parity ? full[7:0] : full[8:1];
	assign rperr = ctrl_q.parity && (^full[7:0] != full[8]);

	always_ff @(posedge I_CLK)
		if (I_RST || (wr_cmd && I_WDATA[`SHCF_CMD_OP_HI:`SHCF_CMD_OP_LO] == `SHCF_OP_HUNT))
		begin
			rhist_q <= 16'h0000;
			rones_q <= 3'h0;
			rcnt_q <= 4'h0;
			rchr_q <= 9'h000;
			hunt_q <= 1'b1;
			lead_q <= 1'b1;
			nchar_q <= 2'h0;
			pend_v_q <= 1'b0;
			pend_q <= '0;
			last_q <= 8'h00;
			rcrc_q <= `SHCF_CRC_INIT;
			push_q <= 1'b0;
			push_e_q <= '0;
			abort_evt_q <= 1'b0;
			hunt_evt_q <= 1'b0;
		end
		else
		begin
			push_q <= 1'b0;
			abort_evt_q <= 1'b0;
			hunt_evt_q <= 1'b0;
			if (rx_stb)
			begin
				rhist_q <= hist_n;
				rones_q <= (rxd_s && rones_q != 3'h7) ? rones_q + 3'h1 : (rxd_s ? rones_q : 3'h0);
				if (sdlc && rxd_s && rones_q == 3'h6)
				begin
					abort_evt_q <= !hunt_q;
					hunt_q <= 1'b1;
					nchar_q <= 2'h0;
					pend_v_q <= 1'b0;
				end
				else if (sdlc && hist_n[15:8] == `SHCF_FLAG)
				begin
					if (!hunt_q && nchar_q == 2'h2 && pend_v_q)
					begin
						push_q <= 1'b1;
						push_e_q <= '{eof: 1'b1, crc_err: rcrc_q != `SHCF_CRC_GOOD,
							par_err: pend_q.par_err, data: {pend_q.data[5:0], last_q[7:6]}};
					end
					hunt_q <= 1'b0;
					rcnt_q <= 4'h0;
					nchar_q <= 2'h0;
					pend_v_q <= 1'b0;
					rcrc_q <= `SHCF_CRC_INIT;
				end
				else if (!sdlc && hunt_q)
				begin
					if ((hist_n >> (5'h10 - slen)) == sync_char)
					begin
						hunt_q <= 1'b0;
						hunt_evt_q <= 1'b1;
						rcnt_q <= 4'h0;
						lead_q <= 1'b1;
					end
				end
				else if (hunt_q || (sdlc && !rxd_s && rones_q == 3'h5))
					rcnt_q <= rcnt_q;
				else if (rcnt_q == (ctrl_q.parity ? 4'h8 : 4'h7))
				begin
					rcnt_q <= 4'h0;
					if (sdlc)
					begin
						push_q <= pend_v_q;
						push_e_q <= pend_q;
						pend_q <= '{eof: 1'b0, crc_err: 1'b0, par_err: rperr, data: rbyte};
						pend_v_q <= 1'b1;
						last_q <= pend_q.data;
						nchar_q <= (nchar_q == 2'h2) ? 2'h2 : nchar_q + 2'h1;
						rcrc_q <= crc_byte(rcrc_q, rbyte);
					end
					else if (!(ctrl_q.sync_inh && lead_q && rbyte == sync_char[7:0]))
					begin
						push_q <= 1'b1;
						push_e_q <= '{eof: 1'b0, crc_err: 1'b0, par_err: rperr, data: rbyte};
						lead_q <= 1'b0;
					end
				end
				else
				begin
					rchr_q <= full;
					rcnt_q <= rcnt_q + 4'h1;
				end
			end
		end

	////////////////////////////////////////////////////////////////////////
	// Receive FIFO, lock and status

	shcf_pkg::shcf_rxent_t fifo_q [3];
	logic [1:0] wp_q;
	logic [1:0] rp_q;
	logic [1:0] fcnt_q;
	logic lock_q;
	logic ovr_q;
	logic first_q;
	shcf_pkg::shcf_rxent_t rstat_q;
	logic pop;
	logic push_ok;
	logic head_spec;
	logic lock_mode;

	assign pop = rd_data && fcnt_q != 2'h0 && !lock_q;
	assign push_ok = push_q && (fcnt_q != `SHCF_FIFO_DEPTH || pop);
	assign head_spec = fifo_q[rp_q].eof || fifo_q[rp_q].crc_err || fifo_q[rp_q].par_err;
	assign lock_mode = ctrl_q.rx_int == shcf_pkg::SHCF_RXI_FIRST
		|| ctrl_q.rx_int == shcf_pkg::SHCF_RXI_SPEC;

	always_ff @(posedge I_CLK)
		if (I_RST)
		begin
			for (int i = 0; i < 3; i++)
				fifo_q[i] <= '0;
			wp_q <= 2'h0;
			rp_q <= 2'h0;
			fcnt_q <= 2'h0;
		end
		else
		begin
			if (push_ok)
			begin
				fifo_q[wp_q] <= push_e_q;
				wp_q <= (wp_q == 2'h2) ? 2'h0 : wp_q + 2'h1;
			end
			if (pop)
				rp_q <= (rp_q == 2'h2) ? 2'h0 : rp_q + 2'h1;
			fcnt_q <= fcnt_q + {1'b0, push_ok} - {1'b0, pop};
		end

	always_ff @(posedge I_CLK)
		if (I_RST)
		begin
			lock_q <= 1'b0;
			ovr_q <= 1'b0;
			rstat_q <= '0;
		end
		else
		begin
			if (pop)
				rstat_q <= fifo_q[rp_q];
			if (pop && head_spec && lock_mode)
				lock_q <= 1'b1;
			else if (err_rst)
				lock_q <= 1'b0;
			if (push_q && !push_ok)
				ovr_q <= 1'b1;
			else if (err_rst)
				ovr_q <= 1'b0;
		end

	// Event pulses
	always_ff @(posedge I_CLK)
		if (I_RST)
		begin
			first_q <= 1'b1;
			O_RX_EVT <= 1'b0;
			O_SPEC_EVT <= 1'b0;
			O_EXT_EVT <= 1'b0;
		end
		else
		begin
			if (push_ok)
				first_q <= 1'b0;
			else if (err_rst)
				first_q <= 1'b1;
			O_RX_EVT <= push_ok && (ctrl_q.rx_int == shcf_pkg::SHCF_RXI_ALL
				|| (ctrl_q.rx_int == shcf_pkg::SHCF_RXI_FIRST && first_q));
			O_SPEC_EVT <= (pop && head_spec && lock_mode)
				|| (push_ok && ctrl_q.rx_int == shcf_pkg::SHCF_RXI_ALL
				&& (push_e_q.eof || push_e_q.crc_err || push_e_q.par_err));
			O_EXT_EVT <= (ctrl_q.ext_ie && (abort_evt_q || hunt_evt_q))
				|| (ctrl_q.eom_ie && load_now
				&& (ld_kind == shcf_pkg::SHCF_TK_CRC || ld_kind == shcf_pkg::SHCF_TK_ABORT));
		end

	assign O_RX_DMA_REQ = fcnt_q != 2'h0 && !lock_q;

	////////////////////////////////////////////////////////////////////////
	// Read port

	assign status = {4'h0, cts_s, search_q, ovr_q, rstat_q.par_err, rstat_q.eof,
		rstat_q.crc_err, lock_q, rones_q == 3'h7, hunt_q, eom_q, fcnt_q != 2'h0, tx_empty_q};

	always_ff @(posedge I_CLK)
		if (I_RST)
			rdata_q <= 16'h0000;
		else if (I_RD)
			unique case (I_ADDR)
				`SHCF_CTRL_REG: rdata_q <= ctrl_q;
				`SHCF_DATA_REG: rdata_q <= {8'h00, fifo_q[rp_q].data};
				`SHCF_STATUS_REG: rdata_q <= status;
				`SHCF_SYNC_REG: rdata_q <= sync_q;
				`SHCF_MISC_CONTROL_REGISTER: rdata_q <= misc_q;
				default: rdata_q <= 16'h0000;
			endcase
		else
			rdata_q <= 16'h0000;

	assign O_RDATA = rdata_q;

endmodule : shcf_framer

// file: hdl/shcf_defs.svh
/*
 * Register offsets, reset values, codes and constants of the framer.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef SHCF_DEFS_SVH
`define SHCF_DEFS_SVH

// Register offsets on the plain port
`define SHCF_COMMAND_REGISTER 3'h0
`define SHCF_CTRL_REG 3'h1
`define SHCF_DATA_REG 3'h2
`define SHCF_STATUS_REG 3'h3
`define SHCF_SYNC_REG 3'h4
`define SHCF_MISC_CONTROL_REGISTER 3'h5

// Reset values
`define SHCF_CTRL_RST 16'h0000
`define SHCF_SYNC_RST 16'h007E
`define SHCF_MISC_RST 16'h1000

// Command register fields and codes
`define SHCF_CMD_CRC_HI 7
`define SHCF_CMD_CRC_LO 6
`define SHCF_CMD_OP_HI 5
`define SHCF_CMD_OP_LO 3
`define SHCF_CRC_TX_RST 2'h1
`define SHCF_CRC_MSG_RST 2'h2
`define SHCF_CRC_RX_RST 2'h3
`define SHCF_OP_ABORT 3'h1
`define SHCF_OP_HUNT 3'h3
`define SHCF_OP_ERR_RST 3'h6

// Misc control fields
`define SHCF_MISC_PLL_SEL 0
`define SHCF_MISC_SEARCH 1
`define SHCF_MISC_DIV_HI 15
`define SHCF_MISC_DIV_LO 8

// Line constants
`define SHCF_FLAG 8'h7E
`define SHCF_ONES 8'hFF
`define SHCF_CRC_INIT 16'hFFFF
`define SHCF_CRC_POLY 16'h8408
`define SHCF_CRC_GOOD 16'hF0B8
`define SHCF_FIFO_DEPTH 2'h3

`endif

// file: hdl/shcf_pkg.sv
/*
 * Types shared by the framer.
 * Assumes shcf_defs.svh supplies the numeric constants.
 */
package shcf_pkg;

	typedef enum logic [1:0] {SHCF_SDLC, SHCF_MONO, SHCF_BISYNC, SHCF_MODE_RSV} shcf_mode_t;
	typedef enum logic [1:0] {SHCF_RXI_OFF, SHCF_RXI_FIRST, SHCF_RXI_ALL, SHCF_RXI_SPEC} shcf_rxi_t;
	typedef enum {SHCF_TK_ABORT, SHCF_TK_SYNC, SHCF_TK_DATA, SHCF_TK_CRC, SHCF_TK_CLOSE,
		SHCF_TK_IDLE} shcf_tkind_t;

	typedef struct packed {
		logic tx_ie;
		logic eom_ie;
		logic ext_ie;
		shcf_rxi_t rx_int;
		logic sync_inh;
		logic idle_ones;
		logic abort_ur;
		logic parity;
		logic auto_en;
		logic [1:0] sync_len;
		shcf_mode_t mode;
		logic rx_en;
		logic tx_en;
	} shcf_ctrl_t;

	typedef struct packed {
		logic eof;
		logic crc_err;
		logic par_err;
		logic [7:0] data;
	} shcf_rxent_t;

endpackage : shcf_pkg

// file: verif/shcf_framer_assertions.sv
/* Port checker for shcf_framer.
   Assumes a bind into every framer instance and one clock domain. */
`timescale 1ns/100ps
`include "shcf_defs.svh"
module shcf_framer_assertions (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [2:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RECEIVE_CLOCK_PIN,
	input wire logic I_TXC,
	input wire logic I_CTS_N,
	input wire logic O_TXD,
	input wire logic O_WREQ,
	input wire logic O_TX_EVT,
	input wire logic O_EXT_EVT,
	input wire logic O_RX_EVT,
	input wire logic O_SPEC_EVT
);
	shcf_pkg::shcf_ctrl_t ctrl_q;
	logic [4:0] txq_q;
	logic [4:0] rxq_q;
	logic txc_q;
	logic rclk_q;
	////////////////////////////////////////////////////////////////////////////////
	// Control shadow
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			ctrl_q <= '0;
		else if (I_WR && I_ADDR == `SHCF_CTRL_REG)
			ctrl_q <= shcf_pkg::shcf_ctrl_t'(I_WDATA);
	end
	// Cycles since a transmit clock edge or a write
	always_ff @(posedge I_CLK)
	begin
		txc_q <= I_TXC;
		if (I_RST || I_WR || I_TXC != txc_q)
			txq_q <= 5'h00;
		else if (txq_q != 5'h1F)
			txq_q <= txq_q + 5'h01;
	end
	// Cycles since a receive clock edge
	always_ff @(posedge I_CLK)
	begin
		rclk_q <= I_RECEIVE_CLOCK_PIN;
		if (I_RST || I_RECEIVE_CLOCK_PIN != rclk_q)
			rxq_q <= 5'h00;
		else if (rxq_q != 5'h1F)
			rxq_q <= rxq_q + 5'h01;
	end
	////////////////////////////////////////////////////////////////////////////////
	auto_halt_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(ctrl_q.auto_en && I_CTS_N) [*5] |-> O_TXD)
		else $error("TXD not high while CTS inactive");
	tx_frozen_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		txq_q >= 5'h08 && !ctrl_q.auto_en |-> $stable(O_TXD))
		else $error("TXD moved without transmit clock");
	tx_event_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_TX_EVT |-> $past(ctrl_q.tx_ie) ##1 !O_TX_EVT)
		else $error("Transmit event without enable or too long");
	ext_event_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_EXT_EVT |-> $past(ctrl_q.ext_ie || ctrl_q.eom_ie))
		else $error("Status event without enable");
	spec_event_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_SPEC_EVT |-> $past(ctrl_q.rx_int) != shcf_pkg::SHCF_RXI_OFF)
		else $error("Special event with receive events off");
	rx_event_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_RX_EVT |-> $past(ctrl_q.rx_int) inside {shcf_pkg::SHCF_RXI_FIRST,
		shcf_pkg::SHCF_RXI_ALL})
		else $error("Character event in wrong mode");
	rx_stall_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		rxq_q >= 5'h10 |-> !O_RX_EVT)
		else $error("Character taken with receive clock stopped");
	wreq_off_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!ctrl_q.tx_en [*3] |-> !O_WREQ)
		else $error("Transmit request with transmitter off");
endmodule : shcf_framer_assertions

bind shcf_framer shcf_framer_assertions u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RECEIVE_CLOCK_PIN(I_RECEIVE_CLOCK_PIN),
	.I_TXC(I_TXC), .I_CTS_N(I_CTS_N), .O_TXD(O_TXD), .O_WREQ(O_WREQ),
	.O_TX_EVT(O_TX_EVT), .O_EXT_EVT(O_EXT_EVT), .O_RX_EVT(O_RX_EVT), .O_SPEC_EVT(O_SPEC_EVT));

// file: verif/shcf_line_peer.sv
/* Serial line peer: sends receive bits, clocks and records the transmitter.
   Assumes a 64 ns bit period, phase unrelated to the system clock. */
`timescale 1ns/100ps
module shcf_line_peer (
	output logic o_rclk,
	output logic o_rxd,
	output logic o_txc,
	input wire logic i_txd
);
	bit got_q[$];
	bit idle = 1'b1;
	initial
	begin
		o_rclk = 1'b1;
		o_txc = 1'b1;
		o_rxd = 1'b1;
	end
	// Data churns while the clock stands still
	always #7.3 if (idle) o_rxd = ~o_rxd;
	task automatic send(input bit b[$]);
		idle = 1'b0;
		#1.3;
		foreach (b[i])
		begin
			o_rclk = 1'b0;
			o_rxd = b[i];
			#32.0;
			o_rclk = 1'b1;
			#32.0;
		end
		idle = 1'b1;
	endtask : send
	task automatic grab(input int n);
		got_q = {};
		#1.7;
		repeat (n)
		begin
			o_txc = 1'b0;
			#32.0;
			o_txc = 1'b1;
			got_q.push_back(i_txd);
			#32.0;
		end
	endtask : grab
endmodule : shcf_line_peer

// file: verif/shcf_framer_tb.sv
/* Bench for shcf_framer: register tasks, framed line traffic, verdict.
   Assumes shcf_line_peer drives both line clocks. */
`timescale 1ns/100ps
`include "shcf_defs.svh"
module shcf_framer_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic cts_n = 1'b0;
	logic [15:0] rdata;
	logic rclk, rxd, txc, txd, wreq, rxdma, txe, exte, rxe, spe;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_ext = 0, n_spec = 0, n_tx = 0, n_wf = 0, run = 0, n_rx = 0;
	logic wq = 1'b0;
	logic [15:0] d;
	logic [15:0] c;
	logic [7:0] got[$];
	bit lq[$];
	always #2 clk = ~clk;
	shcf_framer u_dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .I_RECEIVE_CLOCK_PIN(rclk), .I_RXD(rxd), .I_TXC(txc),
		.I_CTS_N(cts_n), .O_TXD(txd), .O_WREQ(wreq), .O_RX_DMA_REQ(rxdma), .O_TX_EVT(txe),
		.O_EXT_EVT(exte), .O_RX_EVT(rxe), .O_SPEC_EVT(spe));
	shcf_line_peer u_peer (.o_rclk(rclk), .o_rxd(rxd), .o_txc(txc), .i_txd(txd));
	always @(posedge clk)
	begin
		n_ext += (exte === 1'b1);
		n_spec += (spe === 1'b1);
		n_rx += (rxe === 1'b1);
		n_tx += (txe === 1'b1);
		n_wf += (wq === 1'b1 && wreq === 1'b0);
		wq <= wreq;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wreg(input logic [2:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [2:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rreg
	task automatic chk(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
		total_checks++;
		if ((g & m) !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g & m, e);
		end
	endtask : chk
	task automatic final_report();
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	function automatic void put(input logic [7:0] v, input bit st);
		for (int i = 0; i < 8; i++)
		begin
			lq.push_back(v[i]);
			run = v[i] ? run + 1 : 0;
			if (st && run == 5)
			begin
				lq.push_back(1'b0);
				run = 0;
			end
		end
	endfunction : put
	function automatic void frame(input logic [7:0] b[$]);
		c = 16'hFFFF;
		foreach (b[i])
			for (int k = 0; k < 8; k++)
				c = (c[0] ^ b[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
		c = ~c;
		lq = {};
		put(8'h7E, 1'b0);
		put(8'h7E, 1'b0);
		foreach (b[i])
			put(b[i], 1'b1);
		put(c[7:0], 1'b1);
		put(c[15:8], 1'b1);
		put(8'h7E, 1'b0);
	endfunction : frame
	function automatic bit seen();
		for (int s = 0; s + lq.size() <= u_peer.got_q.size(); s++)
		begin
			int k;
			k = 0;
			while (k < lq.size() && u_peer.got_q[s + k] == lq[k])
				k++;
			if (k == lq.size())
				return 1'b1;
		end
		return 1'b0;
	endfunction : seen
	function automatic int maxrun();
		int r, m;
		r = 0;
		m = 0;
		foreach (u_peer.got_q[i])
		begin
			r = u_peer.got_q[i] ? r + 1 : 0;
			m = (r > m) ? r : m;
		end
		return m;
	endfunction : maxrun
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#200000;
		n_mismatch++;
		final_report();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rreg(`SHCF_STATUS_REG, d);
		chk(d, 16'h0004, 16'h0004);
		rreg(3'h7, d);
		chk(d, 16'h0000, 16'hFFFF);
		wreg(`SHCF_CTRL_REG, 16'hC001);
		rreg(`SHCF_CTRL_REG, d);
		chk(d, 16'hC001, 16'hFFFF);
		wreg(`SHCF_COMMAND_REGISTER, 16'h0040);
		frame('{8'h55, 8'hA3});
		fork
			u_peer.grab(120);
			begin
				repeat (300) @(posedge clk);
				wreg(`SHCF_DATA_REG, 16'h0055);
				wreg(`SHCF_COMMAND_REGISTER, 16'h0080);
				rreg(`SHCF_STATUS_REG, d);
				chk(d, 16'h0000, 16'h0004);
				repeat (400)
				begin
					rreg(`SHCF_STATUS_REG, d);
					if (d[0] === 1'b1)
						break;
				end
				wreg(`SHCF_DATA_REG, 16'h00A3);
			end
		join
		chk(16'(seen()), 16'h0001, 16'h0001);
		rreg(`SHCF_STATUS_REG, d);
		chk(d, 16'h0005, 16'h0005);
		chk(16'(n_tx != 0 && n_ext != 0), 16'h0001, 16'h0001);
		n_wf = 0;
		fork
			u_peer.grab(40);
			begin
				repeat (300) @(posedge clk);
				wreg(`SHCF_COMMAND_REGISTER, 16'h0008);
			end
		join
		chk(16'(maxrun() >= 8), 16'h0001, 16'h0001);
		chk(16'(n_wf != 0), 16'h0001, 16'h0001);
		wreg(`SHCF_CTRL_REG, 16'hC041);
		cts_n <= 1'b1;
		u_peer.grab(24);
		chk(16'(maxrun()), 16'h0018, 16'hFFFF);
		cts_n <= 1'b0;
		u_peer.grab(24);
		chk(16'(maxrun() < 24), 16'h0001, 16'h0001);
		wreg(`SHCF_CTRL_REG, 16'h0201);
		u_peer.grab(24);
		chk(16'(maxrun() > 7), 16'h0001, 16'h0001);
		wreg(`SHCF_SYNC_REG, 16'h0003);
		wreg(`SHCF_CTRL_REG, 16'h0015);
		lq = {};
		repeat (2)
			for (int i = 0; i < 6; i++)
				lq.push_back(i < 2);
		u_peer.grab(36);
		chk(16'(seen()), 16'h0001, 16'h0001);
		wreg(`SHCF_CTRL_REG, 16'h2802);
		frame('{8'hC5});
		u_peer.send(lq);
		chk(16'(rxdma), 16'h0001, 16'hFFFF);
		repeat (5)
		begin
			rreg(`SHCF_DATA_REG, d);
			got.push_back(d[7:0]);
			rreg(`SHCF_STATUS_REG, d);
			if (d[7] === 1'b1)
				break;
		end
		chk(16'(got[0]), 16'h00C5, 16'hFFFF);
		chk(16'(got[$]), {8'h00, c[13:8], c[7:6]}, 16'hFFFF);
		chk(d, 16'h00A0, 16'h00E0);
		chk(16'(n_spec), 16'h0001, 16'hFFFF);
		chk(16'(n_rx), 16'h0001, 16'hFFFF);
		wreg(`SHCF_COMMAND_REGISTER, 16'h0030);
		rreg(`SHCF_STATUS_REG, d);
		chk(d, 16'h0000, 16'h0020);
		n_ext = 0;
		lq = {};
		put(8'h7E, 1'b0);
		put(8'h5A, 1'b1);
		put(8'hFF, 1'b0);
		put(8'hFF, 1'b0);
		u_peer.send(lq);
		repeat (20) @(posedge clk);
		chk(16'(n_ext), 16'h0001, 16'hFFFF);
		rreg(`SHCF_STATUS_REG, d);
		chk(d, 16'h0008, 16'h0008);
		final_report();
	end
endmodule : shcf_framer_tb
